// *** test/tb_three_port_gpio_bank.sv ***
`timescale 1ns/1ps
module tb_three_port_gpio_bank
	import tpg_pkg::*;
;
	int n_mismatch = 0, compares = 0;
	logic mclk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rv [15:26], d, e, exA = 8'h00, exB = 8'h00;
	logic [7:0] paPinIn, paPinOut, paPinOe, paPullUp, paDigIn, pbPinIn, pbPinOut, pbPinOe, pbPullUp, pbPullDown;
	logic [3:0] pcPinIn, pcPinOut, pcPinOe, pcPullUp, pcPullDown, pcDigIn, pcWakeReq, pcIrqReq, wk, ir, exC = 4'h5;
	logic [7:0] pbDigIn, enA = 8'hff, enB = 8'hff;
	logic [3:0] enC = 4'hf;
	tpg_gpio_bank tpg_gpio_bank_i (.mclk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .paPinIn,
		.paPinOut, .paPinOe, .paPullUp, .paDigIn, .pbPinIn, .pbPinOut, .pbPinOe, .pbPullUp, .pbPullDown,
		.pbDigIn, .pcPinIn, .pcPinOut, .pcPinOe, .pcPullUp, .pcPullDown, .pcDigIn, .pcWakeReq, .pcIrqReq);
	tpg_pad_model #(.W(8)) padA (.mclk, .pinOut(paPinOut), .pinOe(paPinOe), .pullUp(paPullUp),
		.pullDown(8'h00), .extEn(enA), .extVal(exA), .pinIn(paPinIn));
	tpg_pad_model #(.W(8)) padB (.mclk, .pinOut(pbPinOut), .pinOe(pbPinOe), .pullUp(pbPullUp),
		.pullDown(pbPullDown), .extEn(enB), .extVal(exB), .pinIn(pbPinIn));
	tpg_pad_model #(.W(4)) padC (.mclk, .pinOut(pcPinOut), .pinOe(pcPinOe), .pullUp(pcPullUp),
		.pullDown(pcPullDown), .extEn(enC), .extVal(exC), .pinIn(pcPinIn));
	// ====
	// Bus and compare helpers
	task automatic chk(input string n, input logic [7:0] s, ex);
		compares++;
		if (s !== ex) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, ex, s);
		end
	endtask
	task automatic bus(input logic w, r, input logic [7:0] a, dt);
		regWr <= w;
		regRd <= r;
		regAddr <= a;
		regWdata <= dt;
		@(posedge mclk);
	endtask
	task automatic rc(input logic [7:0] a, ex);
		bus(1'b0, 1'b1, a, 8'h00);
		regRd <= 1'b0;
		@(negedge mclk);
		chk($sformatf("reg %h", a), regRdata, ex);
		@(posedge mclk);
	endtask
	// Readable bits of each offset
	function automatic logic [7:0] msk(input logic [7:0] a);
		case (a)
			TPG_OFF_PC_OUT, TPG_OFF_PC_DIR, TPG_OFF_PC_PU: return TPG_MASK_PC;
			TPG_OFF_PB_PD: return TPG_MASK_PB_PD;
			TPG_OFF_PC_PD: return TPG_MASK_PC_PD;
			default: return (a > 8'h0f && a < 8'h16) ? 8'hff : 8'h00;
		endcase
	endfunction
	task finish_test;
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ====
	// Clock, watchdog and main sequence
	initial forever #4 mclk = ~mclk;
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h0203));
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		@(negedge mclk) chk("pcDigIn", {4'h0, pcDigIn}, 8'h05);
		@(posedge mclk);
		for (int k = 0; k < 3; k++) begin
			exA <= 8'($urandom);
			exB <= 8'($urandom);
			for (int a = 14; a < 28; a++) begin
				d = 8'($urandom);
				bus(1'b1, 1'b0, 8'(a), d);
				if (a > 14 && a < 27) rv[a] = d;
				rc(8'(a), d & msk(8'(a)));
			end
			// Port A and B pads with a pull on are left to it, the rest are driven from outside
			enA <= ~(rv[18] & ~rv[17]);
			enB <= ~((rv[21] & ~rv[20]) | (rv[25] & TPG_MASK_PB_PD));
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			e = rv[17] & ~(rv[16] & 8'h20);
			chk("paPinOe", paPinOe, e);
			chk("paPinOut", paPinOut, rv[16] & 8'hdf);
			chk("paDigIn", paDigIn, (e & rv[16]) | (~e & ((enA & exA) | ~enA)));
			chk("pbPinOut", pbPinOut, rv[19]);
			chk("pbDigIn", pbDigIn, (rv[20] & rv[19]) | (~rv[20] & ((enB & exB) | (rv[21] & ~enB))));
			chk("pcPinOe", {4'h0, pcPinOe}, rv[23] & TPG_MASK_PC);
			chk("paPullUp", paPullUp, rv[18] & ~rv[17]);
			chk("pbPinOe", pbPinOe, rv[20]);
			chk("pbPullUp", pbPullUp, rv[21] & ~rv[20]);
			chk("pbPullDown", pbPullDown, rv[25] & TPG_MASK_PB_PD);
			chk("pcPinOut", {4'h0, pcPinOut}, rv[22] & TPG_MASK_PC);
			chk("pcPullUp", {4'h0, pcPullUp}, rv[24] & ~rv[23] & TPG_MASK_PC);
			chk("pcPullDown", {4'h0, pcPullDown}, rv[26] & TPG_MASK_PC_PD);
			@(posedge mclk);
		end
		bus(1'b1, 1'b0, TPG_OFF_PA_OUT, 8'h20);
		bus(1'b1, 1'b0, TPG_OFF_PA_DIR, 8'hff);
		bus(1'b1, 1'b0, TPG_OFF_PC_DIR, 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		@(negedge mclk) chk("paPinOe", paPinOe, 8'hdf);
		chk("paPinOut", paPinOut, 8'h00);
		@(posedge mclk);
		bus(1'b1, 1'b0, TPG_OFF_PA_OUT, 8'h00);
		bus(1'b1, 1'b0, TPG_OFF_PC_GATE, 8'h09);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		@(negedge mclk) chk("paPinOe", paPinOe, 8'hff);
		@(posedge mclk);
		exC <= 4'h0;
		repeat (8) @(posedge mclk);
		exC <= 4'hf;
		wk = 4'h0;
		ir = 4'h0;
		repeat (8) begin
			@(posedge mclk);
			#1 wk = wk | pcWakeReq;
			ir = ir | pcIrqReq;
		end
		chk("pcWakeReq", {4'h0, wk}, 8'h09);
		chk("pcIrqReq", {4'h0, ir}, 8'h09);
		chk("pcDigIn", {4'h0, pcDigIn}, 8'h09);
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rc(TPG_OFF_PB_OUT, 8'h00);
		rc(TPG_OFF_PC_DIR, 8'h00);
		repeat (3) @(posedge mclk);
		@(negedge mclk) chk("pcDigIn", {4'h0, pcDigIn}, 8'h0f);
		finish_test;
	end
endmodule // tb_three_port_gpio_bank

// *** test/tpg_gpio_bank_assertions.sv ***
`timescale 1ns/1ps
// ====
// Checker on the bank's ports
module tpg_gpio_bank_assertions
	import tpg_pkg::*;
(
	// Clock, reset and register port
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	// Pads
	input wire logic [7:0] paPinOut,
	input wire logic [7:0] paPinOe,
	input wire logic [7:0] paPullUp,
	input wire logic [7:0] pbPinOut,
	input wire logic [7:0] pbPullDown,
	input wire logic [3:0] pcPinOe,
	input wire logic [3:0] pcPullDown,
	input wire logic [3:0] pcDigIn,
	input wire logic [3:0] pcWakeReq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// Pad levels
	a_pa5_never_high: assert property (paPinOe[5] |-> !paPinOut[5])
		else $error("pa5 driven high");
	a_pa5_data_high: assert property (regWr && regAddr == TPG_OFF_PA_OUT && regWdata[5] |=> !paPinOe[5])
		else $error("pa5 enabled with data one");
	a_pa_pullup_input: assert property ((paPullUp & paPinOe) == 8'h00)
		else $error("pa pull-up on output");
	a_pb_pd_bits: assert property ((pbPullDown & 8'hf3) == 8'h00)
		else $error("pb pull-down bit");
	a_pc_pd_bits: assert property (pcPullDown[3:2] == 2'b00)
		else $error("pc pull-down bit");
	a_wake_on_edge: assert property (pcWakeReq != 4'h0 |-> (pcWakeReq & ~(pcDigIn ^ $past(pcDigIn))) == 4'h0)
		else $error("wake without edge");
	// Register port
	a_gate_reads_zero: assert property (regRd && regAddr == TPG_OFF_PC_GATE |=> regRdata == 8'h00)
		else $error("gate readable");
	a_pc_dir_write: assert property (regWr && regAddr == TPG_OFF_PC_DIR |=> pcPinOe == $past(regWdata[3:0]))
		else $error("pc enable mismatch");
	a_pb_out_write: assert property (regWr && regAddr == TPG_OFF_PB_OUT |=> pbPinOut == $past(regWdata))
		else $error("pb drive mismatch");
	c_pa5_low: cover property (paPinOe[5]);
	c_wake: cover property (pcWakeReq != 4'h0);
	c_gate_read: cover property (regRd && regAddr == TPG_OFF_PC_GATE);
endmodule // tpg_gpio_bank_assertions
bind tpg_gpio_bank tpg_gpio_bank_assertions tpg_gpio_bank_assertions_i (.*);

// *** test/tpg_pad_model.sv ***
`timescale 1ns/1ps
// ====
// Pads and outside circuitry of one port
module tpg_pad_model #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic [W-1:0] pinOut,
	input  wire logic [W-1:0] pinOe,
	input  wire logic [W-1:0] pullUp,
	input  wire logic [W-1:0] pullDown,
	input  wire logic [W-1:0] extEn,
	input  wire logic [W-1:0] extVal,
	output logic      [W-1:0] pinIn
);
	logic [W-1:0] flt_r = '0;
	// A floating pad wanders every cycle
	always @(posedge mclk) flt_r <= ~flt_r;
	// Own driver, then outside driver, then pulls
	always_comb begin
		for (int i = 0; i < W; i++) pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] :
			pullUp[i] | (~pullDown[i] & flt_r[i]);
	end
endmodule // tpg_pad_model

// *** verilog/tpg_gpio_bank.sv ***
`timescale 1ns/1ps
module tpg_gpio_bank
	import tpg_pkg::*;
#(
	parameter int PA_W = 8,
	parameter int PB_W = 8,
	parameter int PC_W = 4
) (
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            arst_n,
	// Register port
	input  wire logic [7:0]      regAddr,
	input  wire logic [7:0]      regWdata,
	input  wire logic            regWr,
	input  wire logic            regRd,
	output logic      [7:0]      regRdata,
	// Port A pins
	input  wire logic [PA_W-1:0] paPinIn,
	output logic      [PA_W-1:0] paPinOut,
	output logic      [PA_W-1:0] paPinOe,
	output logic      [PA_W-1:0] paPullUp,
	output logic      [PA_W-1:0] paDigIn,
	// Port B pins
	input  wire logic [PB_W-1:0] pbPinIn,
	output logic      [PB_W-1:0] pbPinOut,
	output logic      [PB_W-1:0] pbPinOe,
	output logic      [PB_W-1:0] pbPullUp,
	output logic      [PB_W-1:0] pbPullDown,
	output logic      [PB_W-1:0] pbDigIn,
	// Port C pins
	input  wire logic [PC_W-1:0] pcPinIn,
	output logic      [PC_W-1:0] pcPinOut,
	output logic      [PC_W-1:0] pcPinOe,
	output logic      [PC_W-1:0] pcPullUp,
	output logic      [PC_W-1:0] pcPullDown,
	output logic      [PC_W-1:0] pcDigIn,
	output logic      [PC_W-1:0] pcWakeReq,
	output logic      [PC_W-1:0] pcIrqReq
);

	// ==========================================================
	// Control registers
	logic [PA_W-1:0] paOut_r, paDir_r, paPu_r;
	logic [PB_W-1:0] pbOut_r, pbDir_r, pbPu_r;
	logic [PC_W-1:0] pcOut_r, pcDir_r, pcPu_r, pcGate_r;
	logic [1:0]      pbPd_r, pcPd_r;

	// ==========================================================
	// Write decode: one select per register, unmapped offsets hit nothing
	logic wrPaOut, wrPaDir, wrPaPu;
	logic wrPbOut, wrPbDir, wrPbPu, wrPbPd;
	logic wrPcGate, wrPcOut, wrPcDir, wrPcPu, wrPcPd;
	always_comb begin
		wrPaOut  = 1'b0;
		wrPaDir  = 1'b0;
		wrPaPu   = 1'b0;
		wrPbOut  = 1'b0;
		wrPbDir  = 1'b0;
		wrPbPu   = 1'b0;
		wrPbPd   = 1'b0;
		wrPcGate = 1'b0;
		wrPcOut  = 1'b0;
		wrPcDir  = 1'b0;
		wrPcPu   = 1'b0;
		wrPcPd   = 1'b0;
		if (regWr) begin
			if (regAddr == TPG_OFF_PC_GATE) begin
				wrPcGate = 1'b1;
			end else if (regAddr == TPG_OFF_PA_OUT) begin
				wrPaOut = 1'b1;
			end else if (regAddr == TPG_OFF_PA_DIR) begin
				wrPaDir = 1'b1;
			end else if (regAddr == TPG_OFF_PA_PU) begin
				wrPaPu = 1'b1;
			end else if (regAddr == TPG_OFF_PB_OUT) begin
				wrPbOut = 1'b1;
			end else if (regAddr == TPG_OFF_PB_DIR) begin
				wrPbDir = 1'b1;
			end else if (regAddr == TPG_OFF_PB_PU) begin
				wrPbPu = 1'b1;
			end else if (regAddr == TPG_OFF_PC_OUT) begin
				wrPcOut = 1'b1;
			end else if (regAddr == TPG_OFF_PC_DIR) begin
				wrPcDir = 1'b1;
			end else if (regAddr == TPG_OFF_PC_PU) begin
				wrPcPu = 1'b1;
			end else if (regAddr == TPG_OFF_PB_PD) begin
				wrPbPd = 1'b1;
			end else if (regAddr == TPG_OFF_PC_PD) begin
				wrPcPd = 1'b1;
			end
		end
	end

	// ==========================================================
	// Port A registers
	// Output data
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			paOut_r <= TPG_RST_ZERO[PA_W-1:0];
		end else if (wrPaOut) begin
			paOut_r <= regWdata[PA_W-1:0];
		end
	end

	// Direction, 1 selects output
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			paDir_r <= TPG_RST_ZERO[PA_W-1:0];
		end else if (wrPaDir) begin
			paDir_r <= regWdata[PA_W-1:0];
		end
	end

	// Pull-up enables
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			paPu_r <= TPG_RST_ZERO[PA_W-1:0];
		end else if (wrPaPu) begin
			paPu_r <= regWdata[PA_W-1:0];
		end
	end

	// ==========================================================
	// Port B registers
	// Output data
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pbOut_r <= TPG_RST_ZERO[PB_W-1:0];
		end else if (wrPbOut) begin
			pbOut_r <= regWdata[PB_W-1:0];
		end
	end

	// Direction, 1 selects output
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pbDir_r <= TPG_RST_ZERO[PB_W-1:0];
		end else if (wrPbDir) begin
			pbDir_r <= regWdata[PB_W-1:0];
		end
	end

	// Pull-up enables
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pbPu_r <= TPG_RST_ZERO[PB_W-1:0];
		end else if (wrPbPu) begin
			pbPu_r <= regWdata[PB_W-1:0];
		end
	end

	// Pull-down enables, only bits 3 and 2 are kept
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pbPd_r <= TPG_RST_ZERO[1:0];
		end else if (wrPbPd) begin
			pbPd_r <= regWdata[3:2];
		end
	end

	// ==========================================================
	// Port C registers; upper bits dropped on write
	// Input gate, write-only, enabled out of reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcGate_r <= PC_W'(TPG_RST_PC_GATE);
		end else if (wrPcGate) begin
			pcGate_r <= regWdata[PC_W-1:0];
		end
	end

	// Output data
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcOut_r <= TPG_RST_ZERO[PC_W-1:0];
		end else if (wrPcOut) begin
			pcOut_r <= regWdata[PC_W-1:0];
		end
	end

	// Direction, 1 selects output
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcDir_r <= TPG_RST_ZERO[PC_W-1:0];
		end else if (wrPcDir) begin
			pcDir_r <= regWdata[PC_W-1:0];
		end
	end

	// Pull-up enables
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcPu_r <= TPG_RST_ZERO[PC_W-1:0];
		end else if (wrPcPu) begin
			pcPu_r <= regWdata[PC_W-1:0];
		end
	end

	// Pull-down enables, only bits 1 and 0 are kept
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcPd_r <= TPG_RST_ZERO[1:0];
		end else if (wrPcPd) begin
			pcPd_r <= regWdata[1:0];
		end
	end

	// ==========================================================
	// Read path: data one cycle after the strobe, zero otherwise
	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		if (regAddr == TPG_OFF_PA_OUT) begin
			rdMux = 8'(paOut_r);
		end else if (regAddr == TPG_OFF_PA_DIR) begin
			rdMux = 8'(paDir_r);
		end else if (regAddr == TPG_OFF_PA_PU) begin
			rdMux = 8'(paPu_r);
		end else if (regAddr == TPG_OFF_PB_OUT) begin
			rdMux = 8'(pbOut_r);
		end else if (regAddr == TPG_OFF_PB_DIR) begin
			rdMux = 8'(pbDir_r);
		end else if (regAddr == TPG_OFF_PB_PU) begin
			rdMux = 8'(pbPu_r);
		end else if (regAddr == TPG_OFF_PC_OUT) begin
			rdMux = 8'(pcOut_r) & TPG_MASK_PC;
		end else if (regAddr == TPG_OFF_PC_DIR) begin
			rdMux = 8'(pcDir_r) & TPG_MASK_PC;
		end else if (regAddr == TPG_OFF_PC_PU) begin
			rdMux = 8'(pcPu_r) & TPG_MASK_PC;
		end else if (regAddr == TPG_OFF_PB_PD) begin
			rdMux = {4'h0, pbPd_r, 2'h0} & TPG_MASK_PB_PD;
		end else if (regAddr == TPG_OFF_PC_PD) begin
			rdMux = {6'h00, pcPd_r} & TPG_MASK_PC_PD;
		end
		// Gate register is write-only and reads as zero
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			regRdata <= rdMux;
		end else begin
			regRdata <= 8'h00;
		end
	end

	// ==========================================================
	// Input synchronisers: three stages, a bit changes once 2nd and 3rd agree
	// Port A pads
	logic [PA_W-1:0] paS1, paS2, paS3, paIn_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{paS1, paS2, paS3, paIn_r} <= '0;
		end else begin
			paS1   <= paPinIn;
			paS2   <= paS1;
			paS3   <= paS2;
			paIn_r <= (~(paS2 ^ paS3) & paS2) | ((paS2 ^ paS3) & paIn_r);
		end
	end

	// Port B pads
	logic [PB_W-1:0] pbS1, pbS2, pbS3, pbIn_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{pbS1, pbS2, pbS3, pbIn_r} <= '0;
		end else begin
			pbS1   <= pbPinIn;
			pbS2   <= pbS1;
			pbS3   <= pbS2;
			pbIn_r <= (~(pbS2 ^ pbS3) & pbS2) | ((pbS2 ^ pbS3) & pbIn_r);
		end
	end

	// Port C pads
	logic [PC_W-1:0] pcS1, pcS2, pcS3, pcIn_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{pcS1, pcS2, pcS3, pcIn_r} <= '0;
		end else begin
			pcS1   <= pcPinIn;
			pcS2   <= pcS1;
			pcS3   <= pcS2;
			pcIn_r <= (~(pcS2 ^ pcS3) & pcS2) | ((pcS2 ^ pcS3) & pcIn_r);
		end
	end

	// ==========================================================
	// Pad control for port A, pin 5 open-drain low only
	genvar gi;
	generate
		for (gi = 0; gi < PA_W; gi++) begin : g_pa
			if (gi == TPG_PA_LOW_ONLY) begin : g_od
				assign paPinOut[gi] = 1'b0;
				assign paPinOe[gi]  = paDir_r[gi] & ~paOut_r[gi];
			end else begin : g_pp
				assign paPinOut[gi] = paOut_r[gi];
				assign paPinOe[gi]  = paDir_r[gi];
			end
		end
	endgenerate

	// Pull-ups act only on input-mode pins
	assign paPullUp = paPu_r & ~paDir_r;
	assign pbPullUp = pbPu_r & ~pbDir_r;
	assign pcPullUp = pcPu_r & ~pcDir_r;

	// Port B and C drivers
	assign pbPinOut = pbOut_r;
	assign pbPinOe  = pbDir_r;
	assign pcPinOut = pcOut_r;
	assign pcPinOe  = pcDir_r;

	// Pull-downs on the few pins that have them
	always_comb begin
		pbPullDown      = '0;
		pbPullDown[3:2] = pbPd_r;
		pcPullDown      = '0;
		pcPullDown[1:0] = pcPd_r;
	end

	// Digital input paths; port C gated for analog use
	assign paDigIn = paIn_r;
	assign pbDigIn = pbIn_r;
	assign pcDigIn = pcIn_r & pcGate_r;

	// Port C wake and interrupt requests on edges of enabled pins
	logic [PC_W-1:0] pcPrev_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pcPrev_r <= '0;
		end else begin
			pcPrev_r <= pcDigIn;
		end
	end
	assign pcWakeReq = (pcDigIn ^ pcPrev_r) & pcGate_r;
	assign pcIrqReq  = (pcDigIn ^ pcPrev_r) & pcGate_r;

endmodule // tpg_gpio_bank

// *** verilog/tpg_pkg.sv ***
package tpg_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] TPG_OFF_PC_GATE   = 8'h0f;
	localparam logic [7:0] TPG_OFF_PA_OUT    = 8'h10;
	localparam logic [7:0] TPG_OFF_PA_DIR    = 8'h11;
	localparam logic [7:0] TPG_OFF_PA_PU     = 8'h12;
	localparam logic [7:0] TPG_OFF_PB_OUT    = 8'h13;
	localparam logic [7:0] TPG_OFF_PB_DIR    = 8'h14;
	localparam logic [7:0] TPG_OFF_PB_PU     = 8'h15;
	localparam logic [7:0] TPG_OFF_PC_OUT    = 8'h16;
	localparam logic [7:0] TPG_OFF_PC_DIR    = 8'h17;
	localparam logic [7:0] TPG_OFF_PC_PU     = 8'h18;
	localparam logic [7:0] TPG_OFF_PB_PD     = 8'h19;
	localparam logic [7:0] TPG_OFF_PC_PD     = 8'h1a;
	// ==========================================================
	// Reset values
	localparam logic [7:0] TPG_RST_ZERO      = 8'h00;
	localparam logic [3:0] TPG_RST_PC_GATE   = 4'hf;
	// ==========================================================
	// Implemented bit masks and special pin positions
	localparam logic [7:0] TPG_MASK_PC       = 8'h0f;
	localparam logic [7:0] TPG_MASK_PB_PD    = 8'h0c;
	localparam logic [7:0] TPG_MASK_PC_PD    = 8'h03;
	localparam int         TPG_PA_LOW_ONLY   = 5;
endpackage
